// ### pmtr_dev.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmtr_regs.svh"
// Program memory end: fetches, table reads, holding register, serial load port
module pmtr_dev
	import pmtr_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter bit EMULATION = 1'b0
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	pmtr_if.dev link,
	output logic debug_active_out,
	output logic pins_shared_func_en_out
);
	// Two-state controller; the phase counter models the four clocks of an instruction cycle
	typedef enum {ST_IDLE, ST_RUN} pmtr_state_e;
	pmtr_state_e state_q;
	logic [1:0] phase_q;
	logic [1:0] cyc_q;
	pmtr_op_e op_q;
	pmtr_tabrd_s tab_q;
	logic [ADDR_W-1:0] fetch_addr_q;
	logic [7:0] table_result_high_byte_wdata_q;
	logic [ADDR_W-1:0] rd_addr;
	logic [15:0] word;
	logic [7:0] table_result_high_byte_q;
	logic [15:0] shift_q;
	logic [15:0] load_word;
	logic [ADDR_W-1:0] load_addr_q;
	logic [3:0] bit_cnt_q;
	logic pck_q;
	logic pck_rise;
	logic load_we;
	logic readback_q;
	logic take;
	logic take_table;
	logic done;
	// Pointer split and store depth are built for a 4K-word space only
	if (ADDR_W != 12) begin : g_bad_addr_w
		$error("pmtr_dev: address width must be 12");
	end
	// A request counts only when it names an operation
	function automatic logic names_op(input logic valid, input pmtr_op_e op);
		names_op = valid && (op != PMTR_OP_NONE);
	endfunction
	// Table address: last-page forms ignore the high pointer
	function automatic logic [ADDR_W-1:0] tab_addr(input logic lp, input logic [7:0] lo,
		input logic [7:0] hi);
		if (lp) begin
			tab_addr = `PMTR_LAST_PAGE | {4'h0, lo};
		end else begin
			tab_addr = {hi[3:0], lo};
		end
	endfunction
	// Ready is combinational so a waiting request is taken on the first idle edge
	assign link.req_ready = (state_q == ST_IDLE);
	assign take = (state_q == ST_IDLE) && names_op(link.req_valid, link.req_op);
	assign take_table = take && (link.req_op == PMTR_OP_TABLE);
	// Store address: live request at take, captured copies while the read runs
	always_comb begin
		rd_addr = fetch_addr_q;
		if (take_table) begin
			rd_addr = tab_addr(link.tabrd.last_page, link.tbl_ptr_low, link.tbl_ptr_high);
		end else if (take) begin
			rd_addr = link.fetch_addr;
		end else if (op_q == PMTR_OP_TABLE) begin
			rd_addr = load_addr_q;
		end
	end
	pmtr_store #(.WORDS(4096), .WIDTH(16)) u_store (
		.ref_clk_in(ref_clk_in),
		.rd_addr_in(rd_addr),
		.rd_data_out(word),
		.wr_en_in(load_we),
		.wr_addr_in(load_addr_q),
		.wr_data_in(load_word)
	);
	// Each instruction cycle is four phases; a table read spans two cycles
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= ST_IDLE;
			phase_q <= 2'h0;
			cyc_q <= 2'h0;
			op_q <= PMTR_OP_NONE;
			tab_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (take) begin
						state_q <= ST_RUN;
						op_q <= link.req_op;
						tab_q <= link.tabrd;
						phase_q <= 2'h0;
						cyc_q <= (link.req_op == PMTR_OP_TABLE) ? `PMTR_TABLE_CYCLES : 2'h1;
					end
				end
				ST_RUN: begin
					phase_q <= phase_q + 2'h1;
					if (phase_q == `PMTR_PHASES) begin
						cyc_q <= cyc_q - 2'h1;
						if (cyc_q == 2'h1) begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	// Request fields are copied at take so the core may move on while the read runs
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fetch_addr_q <= `PMTR_RESET_VECTOR;
			table_result_high_byte_wdata_q <= `PMTR_TABLE_RESULT_HIGH_BYTE_RESET;
		end else if (take) begin
			fetch_addr_q <= link.fetch_addr;
			table_result_high_byte_wdata_q <= link.table_result_high_byte_wdata;
		end
	end
	assign done = (state_q == ST_RUN) && (phase_q == `PMTR_PHASES) && (cyc_q == 2'h1);
	// Completion strobes stand for exactly one clock
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			link.rsp_valid <= 1'b0;
			link.wr_en <= 1'b0;
		end else begin
			link.rsp_valid <= done;
			link.wr_en <= done && (op_q == PMTR_OP_TABLE);
		end
	end
	// Only fetches refresh the fetch word, so it stands until the next fetch ends
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			link.fetch_word <= 16'h0000;
		end else if (done && op_q == PMTR_OP_FETCH) begin
			link.fetch_word <= word;
		end
	end
	// Destination write; standard forms are pinned to sector 0 whatever the upper bits say
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			link.wr_data <= 8'h00;
			link.wr_addr <= 10'h000;
		end else if (done && op_q == PMTR_OP_TABLE) begin
			link.wr_data <= word[7:0];
			link.wr_addr <= tab_q.extended ? tab_q.dest : {`PMTR_SECTOR0, tab_q.dest[7:0]};
		end
	end
	// Holding register: one operation at a time, so result and software write never collide
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			table_result_high_byte_q <= `PMTR_TABLE_RESULT_HIGH_BYTE_RESET;
		end else if (done && op_q == PMTR_OP_TABLE) begin
			table_result_high_byte_q <= word[15:8];
		end else if (done && op_q == PMTR_OP_TABLE_RESULT_HIGH_BYTE_WR) begin
			table_result_high_byte_q <= table_result_high_byte_wdata_q;
		end
	end
	assign link.table_result_high_byte = table_result_high_byte_q;
	// Serial load: sixteen bits, least significant first, one per programmer clock rise
	assign pck_rise = link.prog_serial_clock_pin && !pck_q;
	// The last bit is merged here so the store sees the whole word on the sixteenth rise
	assign load_word = {link.prog_data_to_dev, shift_q[15:1]};
	// A word that completes while a read runs is dropped; loading belongs to an idle core
	assign load_we = pck_rise && (bit_cnt_q == 4'hF) && (state_q == ST_IDLE);
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pck_q <= 1'b0;
			shift_q <= 16'h0000;
			bit_cnt_q <= 4'h0;
		end else begin
			pck_q <= link.prog_serial_clock_pin;
			if (pck_rise) begin
				shift_q <= load_word;
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
		end
	end
	// Load address starts at the reset entry, steps by one per loaded word, else takes each new table address
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			load_addr_q <= `PMTR_RESET_VECTOR;
		end else if (load_we) begin
			load_addr_q <= load_addr_q + 12'h001;
		end else if (take_table) begin
			load_addr_q <= rd_addr;
		end
	end
	// Readback bit comes from a flop; the pin itself is left to the programmer
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			readback_q <= 1'b0;
		end else begin
			readback_q <= word[bit_cnt_q];
		end
	end
	assign link.prog_data_from_dev = readback_q;
	assign link.prog_data_oe = 1'b0;
	// Debug clock is only ever an input; the debug data line is never driven from here
	assign link.debug_data_from_dev = 1'b0;
	assign link.debug_data_oe = 1'b0;
	assign debug_active_out = EMULATION;
	assign pins_shared_func_en_out = !EMULATION;
endmodule // pmtr_dev
`default_nettype wire

// ### pmtr_regs.svh
// Operation
// - Program store holds 4K words of 16 bits
// - Execution starts at word 000H after reset
// - Table address joins high and low pointers
// - Low word byte goes to data destination
// - High byte to holding register, unused zero
// - Every table read takes two instruction cycles
// - Standard forms sector 0, extended any sector
// - Last-page forms use page 0F00H plus offset
// - Holding register is software readable and writable
// - Software avoids table reads in both contexts
// - Programming moves data serially over one pin
// - Only the programmer drives programming pins
// - Debug port: bidirectional data, input-only clock; here the data line is never driven
// - Emulation disables shared pin functions, keeps programming
// - Discarded fetch inserts one dummy cycle; no fetch is ever discarded here
`ifndef PMTR_REGS_SVH
`define PMTR_REGS_SVH
`define PMTR_RESET_VECTOR 12'h000
`define PMTR_LAST_PAGE 12'hF00
`define PMTR_TABLE_RESULT_HIGH_BYTE_RESET 8'h00
`define PMTR_PHASES 2'h3
`define PMTR_TABLE_CYCLES 2'h2
`define PMTR_SECTOR0 2'h0
`endif

// ### pmtr_pkg.sv
package pmtr_pkg;
	typedef enum logic [1:0] {
		PMTR_OP_NONE,
		PMTR_OP_FETCH,
		PMTR_OP_TABLE,
		PMTR_OP_TABLE_RESULT_HIGH_BYTE_WR
	} pmtr_op_e;
	typedef struct packed {
		logic last_page;
		logic extended;
		logic [9:0] dest;
	} pmtr_tabrd_s;
endpackage

// ### pmtr_if.sv
`timescale 1ns/100ps
`default_nettype none
// Core to program memory link, plus the two serial pin pairs
interface pmtr_if;
	import pmtr_pkg::*;
	logic req_valid;
	logic req_ready;
	pmtr_op_e req_op;
	logic [11:0] fetch_addr;
	pmtr_tabrd_s tabrd;
	logic [7:0] tbl_ptr_low;
	logic [7:0] tbl_ptr_high;
	logic [7:0] table_result_high_byte_wdata;
	logic rsp_valid;
	logic [15:0] fetch_word;
	logic [7:0] wr_data;
	logic [9:0] wr_addr;
	logic wr_en;
	logic [7:0] table_result_high_byte;
	logic prog_data_to_dev;
	logic prog_data_from_dev;
	logic prog_data_oe;
	logic prog_serial_clock_pin;
	logic debug_data_to_dev;
	logic debug_data_from_dev;
	logic debug_data_oe;
	logic debug_serial_clock_pin;
	modport dev (
		input req_valid, req_op, fetch_addr, tabrd, tbl_ptr_low, tbl_ptr_high, table_result_high_byte_wdata,
		output req_ready, rsp_valid, fetch_word, wr_data, wr_addr, wr_en, table_result_high_byte,
		input prog_data_to_dev, prog_serial_clock_pin, debug_data_to_dev,
		input debug_serial_clock_pin,
		output prog_data_from_dev, prog_data_oe, debug_data_from_dev, debug_data_oe
	);
	modport core (
		output req_valid, req_op, fetch_addr, tabrd, tbl_ptr_low, tbl_ptr_high, table_result_high_byte_wdata,
		input req_ready, rsp_valid, fetch_word, wr_data, wr_addr, wr_en, table_result_high_byte
	);
endinterface
`default_nettype wire

// ### pmtr_store.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmtr_regs.svh"
// Flop-based program store with one synchronous write port for loading
module pmtr_store #(
	parameter int WORDS = 4096,
	parameter int WIDTH = 16
) (
	input wire logic ref_clk_in,
	input wire logic [$clog2(WORDS)-1:0] rd_addr_in,
	output logic [WIDTH-1:0] rd_data_out,
	input wire logic wr_en_in,
	input wire logic [$clog2(WORDS)-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in
);
	logic [WIDTH-1:0] mem_q [WORDS];
	// Sizes outside this range would break the byte split of a table word
	if (WORDS < 256 || WIDTH < 9 || WIDTH > 16) begin : g_bad_size
		$error("pmtr_store: bad size");
	end
	// Contents are not reset, as in real flash
	always_ff @(posedge ref_clk_in) begin
		if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem_q[rd_addr_in];
	end
endmodule // pmtr_store
`default_nettype wire

// ### pmtr_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmtr_regs.svh"
// Core end: turns user requests into link requests and returns results
module pmtr_core
	import pmtr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	pmtr_if.core link,
	input wire logic user_valid_in,
	output logic user_ready_out,
	input wire logic [1:0] user_op_in,
	input wire logic [11:0] user_fetch_addr_in,
	input wire logic [11:0] user_tabrd_in,
	input wire logic [7:0] user_ptr_low_in,
	input wire logic [7:0] user_ptr_high_in,
	input wire logic [7:0] user_table_result_high_byte_in,
	output logic user_done_out,
	output logic [15:0] user_word_out,
	output logic [7:0] user_high_out
);
	logic [15:0] word_q;
	// Software keeps interrupts off around table reads; nothing enforced here
	assign link.req_valid = user_valid_in;
	assign link.req_op = pmtr_op_e'(user_op_in);
	assign link.fetch_addr = user_fetch_addr_in;
	assign link.tabrd = pmtr_tabrd_s'(user_tabrd_in);
	assign link.tbl_ptr_low = user_ptr_low_in;
	assign link.tbl_ptr_high = user_ptr_high_in;
	assign link.table_result_high_byte_wdata = user_table_result_high_byte_in;
	assign user_ready_out = link.req_ready;
	assign user_done_out = link.rsp_valid;
	assign user_high_out = link.table_result_high_byte;
	// Capture the fetched word or the table low byte
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			word_q <= 16'h0000;
		end else if (link.wr_en) begin
			word_q <= {8'h00, link.wr_data};
		end else if (link.rsp_valid) begin
			word_q <= link.fetch_word;
		end
	end
	assign user_word_out = word_q;
endmodule // pmtr_core
`default_nettype wire

// ### pmtr_chk.sv
`timescale 1ns/100ps
`default_nettype none
// Link watcher between the core end and the program memory end
module pmtr_chk
	import pmtr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire pmtr_op_e req_op,
	input wire pmtr_tabrd_s tabrd,
	input wire logic rsp_valid,
	input wire logic wr_en,
	input wire logic [9:0] wr_addr,
	input wire logic [7:0] table_result_high_byte,
	input wire logic prog_data_oe,
	input wire logic debug_data_oe
);
	logic ext_q;
	logic [9:0] dst_q;
	wire logic taken = req_valid && req_ready && (req_op != PMTR_OP_NONE);
	// Keep the form of the taken request, the write lands nine cycles later
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ext_q <= 1'b0;
			dst_q <= 10'h000;
		end else if (taken) begin
			ext_q <= tabrd.extended;
			dst_q <= tabrd.dest;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	chk_table_two_cycle: assert property (taken && req_op == PMTR_OP_TABLE |-> ##9 rsp_valid)
		else $error("table answer off time");
	chk_fetch_answer: assert property (taken && req_op == PMTR_OP_FETCH |-> ##5 rsp_valid)
		else $error("fetch answer off time");
	chk_busy_after_take: assert property (taken |=> !req_ready [*4])
		else $error("ready during read");
	chk_write_with_answer: assert property (wr_en |-> rsp_valid ##1 !wr_en)
		else $error("stray write");
	chk_std_sector_zero: assert property (wr_en && !ext_q |-> wr_addr == {2'h0, dst_q[7:0]})
		else $error("standard dest wrong");
	chk_ext_any_sector: assert property (wr_en && ext_q |-> wr_addr == dst_q)
		else $error("extended dest wrong");
	chk_high_byte_hold: assert property ($changed(table_result_high_byte) |-> rsp_valid)
		else $error("high byte moved");
	chk_prog_pin_free: assert property (!prog_data_oe)
		else $error("prog pin driven");
	chk_debug_pin_free: assert property (!debug_data_oe)
		else $error("debug pin driven");
	cover property (taken && req_op == PMTR_OP_FETCH);
	cover property (taken && req_op == PMTR_OP_TABLE && tabrd.last_page);
	cover property (wr_en && ext_q);
	cover property (taken && req_op == PMTR_OP_TABLE_RESULT_HIGH_BYTE_WR);
endmodule // pmtr_chk
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pmtr_pkg::*;
	logic ref_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic u_valid = 1'b0;
	logic u_ready, u_done, shr_en, dbg_act;
	logic [1:0] u_op = 2'h0;
	logic [11:0] u_fa = 12'h000;
	logic [11:0] u_tab = 12'h000;
	logic [7:0] u_lo = 8'h00;
	logic [7:0] u_hi = 8'h00;
	logic [7:0] u_tw = 8'h00;
	logic [7:0] u_high;
	logic [15:0] u_word;
	logic seen_we;
	logic [7:0] seen_wd;
	logic [9:0] seen_wa;
	int last_wait = 0;
	logic [15:0] mem [4096];
	int fail_count = 0;
	int check_count = 0;
	pmtr_if pmtr_if_i();
	pmtr_dev pmtr_dev_i(.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .link(pmtr_if_i),
		.debug_active_out(dbg_act), .pins_shared_func_en_out(shr_en));
	pmtr_core pmtr_core_i(.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .link(pmtr_if_i),
		.user_valid_in(u_valid), .user_ready_out(u_ready), .user_op_in(u_op),
		.user_fetch_addr_in(u_fa), .user_tabrd_in(u_tab), .user_ptr_low_in(u_lo),
		.user_ptr_high_in(u_hi), .user_table_result_high_byte_in(u_tw), .user_done_out(u_done),
		.user_word_out(u_word), .user_high_out(u_high));
	pmtr_chk pmtr_chk_i(.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
		.req_valid(pmtr_if_i.req_valid), .req_ready(pmtr_if_i.req_ready),
		.req_op(pmtr_if_i.req_op), .tabrd(pmtr_if_i.tabrd), .rsp_valid(pmtr_if_i.rsp_valid),
		.wr_en(pmtr_if_i.wr_en), .wr_addr(pmtr_if_i.wr_addr),
		.table_result_high_byte(pmtr_if_i.table_result_high_byte),
		.prog_data_oe(pmtr_if_i.prog_data_oe), .debug_data_oe(pmtr_if_i.debug_data_oe));
	// Free running 10 MHz clock
	always #50 ref_clk_in = ~ref_clk_in;
	task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One request held until taken, then a bounded wait for the answer
	task automatic run(pmtr_op_e op, logic [11:0] fa, logic [11:0] tab, logic [15:0] p, logic [7:0] tw);
		int n;
		n = 0;
		@(negedge ref_clk_in);
		u_valid = 1'b1;
		u_op = op;
		u_fa = fa;
		u_tab = tab;
		{u_hi, u_lo} = p;
		u_tw = tw;
		@(posedge ref_clk_in iff u_ready === 1'b1);
		@(negedge ref_clk_in);
		u_valid = 1'b0;
		// Look at the answer at falling edges, while its one-cycle strobes stand
		while (u_done !== 1'b1 && n < 40) begin
			@(negedge ref_clk_in);
			n++;
		end
		last_wait = n;
		seen_we = pmtr_if_i.wr_en;
		seen_wd = pmtr_if_i.wr_data;
		seen_wa = pmtr_if_i.wr_addr;
		// The core registers its copy of the result one clock later
		@(negedge ref_clk_in);
		if (n >= 40) begin
			fail_count++;
			$display("[ERR] answer expected 1 seen 0");
		end
	endtask
	// Serial load, LSB first; the line shows the inverse once released
	task automatic load(logic [15:0] w);
		for (int i = 0; i < 16; i++) begin
			@(negedge ref_clk_in);
			pmtr_if_i.prog_data_to_dev = w[i];
			pmtr_if_i.prog_serial_clock_pin = 1'b0;
			@(negedge ref_clk_in);
			pmtr_if_i.prog_serial_clock_pin = 1'b1;
		end
		@(negedge ref_clk_in);
		pmtr_if_i.prog_serial_clock_pin = 1'b0;
		pmtr_if_i.prog_data_to_dev = ~w[15];
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Watchdog: the tests need well under two thousand cycles
	initial begin
		#(30000 * 100);
		fail_count++;
		wrap_up();
	end
	// Main sequence, debug pins tied idle
	initial begin
		logic [31:0] r;
		logic [11:0] ad;
		pmtr_if_i.prog_data_to_dev = 1'b0;
		pmtr_if_i.prog_serial_clock_pin = 1'b0;
		pmtr_if_i.debug_data_to_dev = 1'b0;
		pmtr_if_i.debug_serial_clock_pin = 1'b0;
		void'($urandom(32'h5E9D));
		repeat (16) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		arst_n_in = 1'b1;
		chk("table_result_high_byte_reset", 16'h0000, {8'h00, u_high});
		chk("shared_en", 16'h0001, {15'h0000, shr_en});
		chk("debug_active", 16'h0000, {15'h0000, dbg_act});
		r = $urandom;
		load(r[15:0]);
		mem[0] = r[15:0];
		run(PMTR_OP_FETCH, 12'h000, 12'h000, 16'h0000, 8'h00);
		chk("reset_word", mem[0], u_word);
		$display("reset test done");
		for (int k = 0; k < 8; k++) begin
			r = $urandom;
			r[27:26] = k[1:0];
			ad = r[27] ? {4'hF, r[7:0]} : {r[11:8], r[7:0]};
			run(PMTR_OP_TABLE, 12'h000, r[27:16], r[15:0], 8'h00);
			load(r[31:16] ^ r[15:0]);
			mem[ad] = r[31:16] ^ r[15:0];
			run(PMTR_OP_TABLE, 12'h000, r[27:16], r[15:0], 8'h00);
			chk("table_cycles", 16'h0008, 16'(last_wait));
			chk("low_byte", {8'h00, mem[ad][7:0]}, {8'h00, seen_wd});
			chk("wr_pulse", 16'h0001, {15'h0000, seen_we});
			chk("user_low", {8'h00, mem[ad][7:0]}, u_word);
			chk("high_byte", {8'h00, mem[ad][15:8]}, {8'h00, u_high});
			chk("dest", {6'h00, r[26] ? r[25:16] : {2'h0, r[23:16]}}, {6'h00, seen_wa});
			run(PMTR_OP_FETCH, ad, 12'h000, 16'h0000, 8'h00);
			chk("fetch_cycles", 16'h0004, 16'(last_wait));
			chk("fetch", mem[ad], u_word);
		end
		$display("table test done");
		r = $urandom;
		run(PMTR_OP_TABLE_RESULT_HIGH_BYTE_WR, 12'h000, 12'h000, 16'h0000, r[7:0]);
		chk("table_result_high_byte_write", {8'h00, r[7:0]}, {8'h00, u_high});
		$display("holding test done");
		wrap_up();
	end
endmodule // tb
`default_nettype wire
